// >>> rtl/s16t_pkg.sv
package s16t_pkg;
   localparam logic [1:0] OFS_CONTROL    = 2'h0;
   localparam logic [1:0] OFS_COUNT_LOW  = 2'h1;
   localparam logic [1:0] OFS_COUNT_HIGH = 2'h2;
   localparam logic [1:0] OFS_STATUS     = 2'h3;

   localparam int unsigned CTL_TIMER_RUN      = 0;
   localparam int unsigned CTL_CLOCK_SOURCE   = 1;
   localparam int unsigned CTL_SYNC_BYPASS    = 2;
   localparam int unsigned CTL_ASSIGN_LO      = 3;
   localparam int unsigned CTL_PRESCALE_LO    = 4;
   localparam int unsigned CTL_PRESCALE_HI    = 5;
   localparam int unsigned CTL_ASSIGN_HI      = 6;
   localparam int unsigned CTL_WIDE_ACCESS    = 7;

   localparam int unsigned STS_OVERFLOW_FLAG  = 0;
   localparam int unsigned STS_OVERFLOW_IRQEN = 1;
   localparam int unsigned STS_SHARED_OSC_EN  = 2;

   localparam logic [7:0]  CONTROL_RESET      = 8'h00;
   localparam logic [2:0]  STATUS_RESET       = 3'h0;
   localparam logic [15:0] COUNT_RESET        = 16'h0000;
   localparam logic [15:0] COUNT_TOP          = 16'hFFFF;
   localparam logic [3:0]  MODE_SPECIAL_EVENT = 4'hB;
   localparam int unsigned CHANNELS           = 5;
endpackage

// >>> rtl/s16t_tick_if.sv
`timescale 1ns/1ps
interface s16t_tick_if;
   logic [1:0] pin_raw;
   logic [1:0] pin_sync;
   logic       ext_sel;
   logic       osc_en;
   logic       bypass;
   logic       run;
   logic       tick;

   modport front (
      input  pin_raw,
      input  ext_sel,
      input  osc_en,
      input  bypass,
      input  run,
      output pin_sync,
      output tick
   );
   modport core (
      output pin_raw,
      output ext_sel,
      output osc_en,
      output bypass,
      output run,
      input  pin_sync,
      input  tick
   );
endinterface

// >>> rtl/s16t_clock_front.sv
`timescale 1ns/1ps
module s16t_clock_front (
   input wire logic clock,
   input wire logic rst_n,
   s16t_tick_if.front tk
);
   logic [1:0] meta_r;
   logic [1:0] sync_r;
   logic       align_r;
   logic       prev_r;
   logic       armed_r;
   logic       src;
   logic       level;
   logic       tick_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 2'h0;
         sync_r <= 2'h0;
      end else begin
         meta_r <= tk.pin_raw;
         sync_r <= meta_r;
      end
   end

   // Oscillator enabled selects the oscillator pin as the count source.
   assign src = tk.osc_en ? sync_r[1] : sync_r[0];

   // Synchronised mode adds an instruction-cycle alignment stage; bypass skips it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         align_r <= 1'b0;
      end else begin
         align_r <= src;
      end
   end

   assign level = tk.bypass ? src : align_r; // see R5

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_r  <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         prev_r <= level;
         if (!tk.ext_sel) begin
            armed_r <= 1'b0;
         end else if (prev_r && !level) begin
            armed_r <= 1'b1; // see R3
         end
      end
   end

   // Internal source ticks every instruction cycle while the timer runs.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= 1'b0;
      end else if (!tk.ext_sel) begin
         tick_r <= tk.run; // see R3
      end else begin
         tick_r <= tk.run && armed_r && !prev_r && level; // see R3
      end
   end

   assign tk.tick     = tick_r;
   assign tk.pin_sync = sync_r;
endmodule

// >>> rtl/s16t_timer.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Operation
// R1: Count up 0000h to FFFFh, wrap overflows.
// R2: Overflow latches flag; interrupt only when enabled.
// R3: Internal clock at 0, external rising-after-falling at 1.
// R4: Prescale field divides 1, 2, 4, 8.
// R5: External clock synchronised unless bypass bit set.
// R6: Counter advances only while timer runs.
// R7: Wide access bit picks buffered 16-bit access.
// R8: Low read copies high byte to buffer.
// R9: High write fills buffer; low write transfers.
// R10: Low write clears prescaler; high write does not.
// R11: Assign field routes timers to five channels.
// R12: Channel 1/2 special event resets counter.
// R13: Software avoids special reset in asynchronous mode.
// R14: Software counter write beats special event reset.
// R15: Special event reset never sets overflow flag.
// R16: Channel 2 trigger starts enabled conversion.
// R17: Oscillator use needs enable and source select.
// R18: Oscillator pins inputs, port reads return zero.
// R19: Control register resets to all zeros.
// R20: Stopped counter holds and resumes its value.
module s16t_timer (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic [1:0] pin_in,
   input  wire logic [1:0] port_out,
   input  wire logic [1:0] port_dir_out,
   output logic      [1:0] pin_out,
   output logic      [1:0] pin_oe,
   output logic      [1:0] port_read,
   input  wire logic       cmp1_match,
   input  wire logic [3:0] cmp1_mode,
   input  wire logic       cmp2_match,
   input  wire logic [3:0] cmp2_mode,
   input  wire logic       adc_enable,
   output logic            adc_start,
   output logic [4:0]      ch_second_pair,
   output logic            overflow_irq,
   output logic [15:0]     count_value
);
   logic [7:0]  control_r;
   logic [2:0]  status_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [7:0]  high_buf_r;
   logic [2:0]  presc_r;
   logic [2:0]  presc_mask;
   logic [7:0]  rd_data_r;
   logic        adc_start_r;
   logic [4:0]  ch_second_r;
   logic        irq_r;
   logic [1:0]  pin_out_r;
   logic [1:0]  pin_oe_r;
   logic [1:0]  port_read_r;

   // Decoded strobes and selections, all on this clock.
   logic        wide;
   logic        osc_en;
   logic        wr_low;
   logic        wr_high;
   logic        rd_low;
   logic        count_step;
   logic        wrap;
   logic        ch1_here;
   logic        ch2_here;
   logic        special1;
   logic        special2;
   logic        special_reset;
   logic [1:0]  assign_sel;
   logic        wr_ctrl;
   logic        wr_stat;

   // The clock front owns the pin synchroniser and the edge detector, so every
   // pin sample reaches this module already in the clock domain.
   s16t_tick_if tk ();

   s16t_clock_front u_front (
      .clock (clock),
      .rst_n (rst_n),
      .tk    (tk)
   );

   assign wide       = control_r[s16t_pkg::CTL_WIDE_ACCESS];
   assign osc_en     = status_r[s16t_pkg::STS_SHARED_OSC_EN];
   assign assign_sel = {control_r[s16t_pkg::CTL_ASSIGN_HI], control_r[s16t_pkg::CTL_ASSIGN_LO]};
   assign wr_low     = wr_en && (addr == s16t_pkg::OFS_COUNT_LOW);
   assign wr_high    = wr_en && (addr == s16t_pkg::OFS_COUNT_HIGH);
   assign rd_low     = rd_en && (addr == s16t_pkg::OFS_COUNT_LOW);
   // The bus never waits, so each decoded strobe lasts exactly one cycle.
   assign wr_ctrl    = wr_en && (addr == s16t_pkg::OFS_CONTROL);
   assign wr_stat    = wr_en && (addr == s16t_pkg::OFS_STATUS);

   // The timer-on bit gates ticks both here and in the front, so a tick already
   // in flight when the timer stops cannot advance the counter.
   assign tk.pin_raw = pin_in;
   assign tk.ext_sel = control_r[s16t_pkg::CTL_CLOCK_SOURCE]; // see R17
   assign tk.osc_en  = osc_en;
   assign tk.bypass  = control_r[s16t_pkg::CTL_SYNC_BYPASS];
   assign tk.run     = control_r[s16t_pkg::CTL_TIMER_RUN]; // see R6

   // The prescaler counts ticks from zero up to the mask, then restarts; a mask of zero passes every tick.
   always_comb begin
      case (control_r[s16t_pkg::CTL_PRESCALE_HI:s16t_pkg::CTL_PRESCALE_LO])
         2'h0:    presc_mask = 3'h0; // see R4
         2'h1:    presc_mask = 3'h1;
         2'h2:    presc_mask = 3'h3;
         2'h3:    presc_mask = 3'h7;
         default: presc_mask = 3'h0;
      endcase
   end

   // A tick only reaches the counter while running, so a stopped counter holds.
   assign count_step = tk.tick && tk.run && (presc_r == presc_mask); // see R6 R20
   assign wrap       = count_step && (count_r == s16t_pkg::COUNT_TOP); // see R1

   // Only a low-byte write clears the prescaler, so a high-byte write between
   // the two halves of a wide write does not disturb the division phase.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         presc_r <= 3'h0;
      end else if (wr_low) begin
         presc_r <= 3'h0; // see R10
      end else if (tk.tick && tk.run) begin
         presc_r <= (presc_r == presc_mask) ? 3'h0 : presc_r + 3'h1; // see R4
      end
   end

   // Channel 1 runs on this timer only with assignment 11; channel 2 with 01 or 11.
   assign ch1_here      = (assign_sel == 2'h3); // see R11
   assign ch2_here      = assign_sel[0]; // see R11
   assign special1      = ch1_here && cmp1_match && (cmp1_mode == s16t_pkg::MODE_SPECIAL_EVENT);
   assign special2      = ch2_here && cmp2_match && (cmp2_mode == s16t_pkg::MODE_SPECIAL_EVENT);
   assign special_reset = special1 || special2; // see R12

   // Asynchronous counting is not guarded here: the reset is taken in any mode,
   // and software must keep to timer or synchronous counting when relying on it.
   // Priority: a counter write beats a special event reset, which beats a count.
   // In wide mode a high-byte write only fills the buffer and leaves the counter.
   always_comb begin
      count_nxt = count_r;
      if (wr_low) begin
         count_nxt[7:0] = wr_data;
         if (wide) begin
            count_nxt[15:8] = high_buf_r; // see R9
         end
      end else if (wr_high && !wide) begin
         count_nxt[15:8] = wr_data; // see R7
      end else if (wr_high) begin
         count_nxt = count_r; // see R9
      end else if (special_reset) begin
         count_nxt = s16t_pkg::COUNT_RESET; // see R12 R14
      end else if (count_step) begin
         count_nxt = count_r + 16'h0001; // see R1
      end
   end

   // The counter register itself only takes the next value chosen above.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= s16t_pkg::COUNT_RESET;
      end else begin
         count_r <= count_nxt;
      end
   end

   // The buffer serves both directions in wide mode: a low read captures the
   // live high byte, a high write parks the byte until the low write arrives.
   // Reads of the high address therefore see a coherent pair across a carry.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         high_buf_r <= 8'h00;
      end else if (wr_high && wide) begin
         high_buf_r <= wr_data; // see R9
      end else if (rd_low && wide) begin
         high_buf_r <= count_r[15:8]; // see R8
      end
   end

   // Control resets to zero: stopped, internal clock, 1:1 and byte access.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control_r <= s16t_pkg::CONTROL_RESET; // see R19
      end else if (wr_ctrl) begin
         control_r <= wr_data;
      end
   end

   // A wrap in the same cycle as a software clear keeps the flag set.
   // A special event reset or a written value never counts as a wrap.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= s16t_pkg::STATUS_RESET;
      end else begin
         if (wr_stat) begin
            status_r <= wr_data[2:0];
         end
         if (wrap && !wr_low && !wr_high && !special_reset) begin
            status_r[s16t_pkg::STS_OVERFLOW_FLAG] <= 1'b1; // see R2 R15
         end
      end
   end

   // The request follows the flag one cycle late; clearing the flag clears it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= status_r[s16t_pkg::STS_OVERFLOW_FLAG]
                  && status_r[s16t_pkg::STS_OVERFLOW_IRQEN]; // see R2
      end
   end

   // A counter write in the same cycle suppresses the conversion start as well,
   // so a discarded reset never leaves a trace elsewhere.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         adc_start_r <= 1'b0;
      end else begin
         adc_start_r <= special2 && adc_enable && !wr_low && !wr_high; // see R16
      end
   end

   // Bit n high means channel n+1 uses the second timer pair.
   // Routing is a pure decode of the assignment field, registered so that
   // the channel selects change without glitches.
   genvar ch;
   generate
      for (ch = 0; ch < s16t_pkg::CHANNELS; ch = ch + 1) begin : g_route
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               ch_second_r[ch] <= 1'b0;
            end else if (ch == 0) begin
               ch_second_r[ch] <= (assign_sel == 2'h3); // see R11
            end else if (ch == 1) begin
               ch_second_r[ch] <= assign_sel[0]; // see R11
            end else begin
               ch_second_r[ch] <= (assign_sel != 2'h0); // see R11
            end
         end
      end
   endgenerate

   // The port value passes through unchanged; only its drive enable is overridden.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_r <= 2'h0;
      end else begin
         pin_out_r <= port_out;
      end
   end

   // The oscillator owns both pins while enabled, so the port may not drive them.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_oe_r <= 2'h0;
      end else begin
         pin_oe_r <= osc_en ? 2'h0 : port_dir_out; // see R18
      end
   end

   // With the oscillator enabled, port reads of its pins return zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port_read_r <= 2'h0;
      end else begin
         port_read_r <= osc_en ? 2'h0 : tk.pin_sync; // see R18
      end
   end

   // Read data stand one cycle after the strobe and are zero otherwise, which
   // lets a master combine several slaves' read buses with a plain OR.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            s16t_pkg::OFS_CONTROL:    rd_data_r <= control_r;
            s16t_pkg::OFS_COUNT_LOW:  rd_data_r <= count_r[7:0];
            s16t_pkg::OFS_COUNT_HIGH: rd_data_r <= wide ? high_buf_r : count_r[15:8]; // see R8
            s16t_pkg::OFS_STATUS:     rd_data_r <= {5'h00, status_r};
            default:                  rd_data_r <= 8'h00;
         endcase
      end else begin
         rd_data_r <= 8'h00;
      end
   end

   // Every output comes straight from a register.
   assign rd_data        = rd_data_r;
   assign adc_start      = adc_start_r;
   assign ch_second_pair = ch_second_r;
   assign overflow_irq   = irq_r;
   assign pin_out        = pin_out_r;
   assign pin_oe         = pin_oe_r;
   assign port_read      = port_read_r;
   assign count_value    = count_r;
endmodule

// >>> verif/s16t_timer_props.sv
`timescale 1ns/1ps
module s16t_timer_props (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [1:0]  addr,
   input wire logic [7:0]  wr_data,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  rd_data,
   input wire logic [1:0]  pin_in,
   input wire logic [1:0]  port_out,
   input wire logic [1:0]  port_dir_out,
   input wire logic [1:0]  pin_out,
   input wire logic [1:0]  pin_oe,
   input wire logic [1:0]  port_read,
   input wire logic        cmp1_match,
   input wire logic [3:0]  cmp1_mode,
   input wire logic        cmp2_match,
   input wire logic [3:0]  cmp2_mode,
   input wire logic        adc_enable,
   input wire logic        adc_start,
   input wire logic [4:0]  ch_second_pair,
   input wire logic        overflow_irq,
   input wire logic [15:0] count_value
);
   logic [7:0] cnt_lo;
   logic       cnt_wr;
   assign cnt_lo = count_value[7:0];
   assign cnt_wr = wr_en && (addr == 2'h1 || addr == 2'h2);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   a_read_low: assert property (rd_en && addr == 2'h1 |=> rd_data == $past(cnt_lo))
      else $error("low byte read wrong");
   a_count_step: assert property (count_value != $past(count_value) && !$past(wr_en)
      && !$past(cmp1_match) && !$past(cmp2_match)
      |-> count_value == $past(count_value) + 16'h0001)
      else $error("counter moved by other than one");
   a_adc_cause: assert property (adc_start |-> $past(cmp2_match) && $past(adc_enable)
      && $past(cmp2_mode) == 4'hB && !$past(cnt_wr))
      else $error("conversion start without cause");
   a_adc_pulse: assert property (adc_start && !cmp2_match |=> !adc_start)
      else $error("conversion start too long");
   a_assign_map: assert property (ch_second_pair inside {5'h00, 5'h1E, 5'h1C, 5'h1F})
      else $error("channel routing illegal");
   a_oe_from_dir: assert property ((pin_oe & ~$past(port_dir_out)) == 2'h0)
      else $error("pin driven without direction");
   a_out_copy: assert property (pin_out == $past(port_out))
      else $error("pin output not a copy");
   c_adc: cover property (adc_start);
   c_wrap: cover property (count_value == 16'h0000 && $past(count_value) == 16'hFFFF);
   c_irq: cover property (overflow_irq);
endmodule

// >>> verif/s16t_ext_model.sv
`timescale 1ns/1ps
module s16t_ext_model (
   input  wire logic       clock,
   input  wire logic       go,
   output logic            busy,
   output logic      [1:0] pin_in
);
   // The count pin rests low, so a burst's first rise meets an unarmed counter.
   initial begin
      busy = 1'b0;
      pin_in = 2'h2;
   end
   always @(posedge go) begin
      busy <= 1'b1;
      repeat (3) begin
         repeat (4) @(posedge clock);
         pin_in[0] <= 1'b1;
         repeat (4) @(posedge clock);
         pin_in[0] <= 1'b0;
      end
      busy <= 1'b0;
   end
endmodule

// >>> verif/tb_s16t_timer.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
bind s16t_timer s16t_timer_props u_props (.clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
   .rd_data, .pin_in, .port_out, .port_dir_out, .pin_out, .pin_oe, .port_read, .cmp1_match,
   .cmp1_mode, .cmp2_match, .cmp2_mode, .adc_enable, .adc_start, .ch_second_pair,
   .overflow_irq, .count_value);
module tb_s16t_timer;
   logic        clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, go = 1'b0;
   logic        cmp1_match = 1'b0, cmp2_match = 1'b0, adc_enable = 1'b1;
   logic [1:0]  addr = 2'h0, port_out = 2'h0, port_dir_out = 2'h0;
   logic [3:0]  cmp1_mode = 4'hB, cmp2_mode = 4'hB;
   logic [7:0]  wr_data = 8'h00, rd_data;
   logic [1:0]  pin_in, pin_out, pin_oe, port_read;
   logic        adc_start, overflow_irq, busy;
   logic [4:0]  ch_second_pair;
   logic [4:0]  map [4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
   logic [15:0] count_value, v;
   int          n_fail = 0, checked = 0, n;
   always #2.5 clock = ~clock;
   s16t_timer uut (.clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .pin_in,
      .port_out, .port_dir_out, .pin_out, .pin_oe, .port_read, .cmp1_match, .cmp1_mode,
      .cmp2_match, .cmp2_mode, .adc_enable, .adc_start, .ch_second_pair, .overflow_irq,
      .count_value);
   s16t_ext_model ext (.clock, .go, .busy, .pin_in);
   task automatic wrap_up();
      if (n_fail == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Strobes are held until the next call, so no signal is assigned twice in one step.
   task automatic op(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wr_data <= d;
      @(posedge clock);
   endtask
   task automatic idle(input int k);
      repeat (k) op(1'b0, 1'b0, 2'h0, 8'h00);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      op(1'b0, 1'b1, a, 8'h00);
      idle(1);
      `CHK("rd_data", e, rd_data)
   endtask
   task automatic gap(output int c);
      v = count_value;
      c = 0;
      while (count_value === v && c < 40) begin
         idle(1);
         c++;
      end
      if (c == 40) begin
         n_fail++;
         wrap_up();
      end
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(2'h0, 8'h00);
      rd(2'h3, 8'h00);
      wr(2'h1, 8'hFE);
      wr(2'h2, 8'hFF);
      wr(2'h3, 8'h02);
      wr(2'h0, 8'h01);
      idle(6);
      wr(2'h0, 8'h00);
      rd(2'h3, 8'h03);
      `CHK("overflow_irq", 1'b1, overflow_irq)
      v = count_value;
      idle(4);
      `CHK("count_hold", v, count_value)
      for (int p = 0; p < 4; p++) begin
         wr(2'h0, 8'h01 | 8'(p << 4));
         gap(n);
         gap(n);
         `CHK("tick_gap", 1 << p, n)
      end
      for (int i = 0; i < 4; i++) begin
         wr(2'h0, {1'b0, i[1], 2'h0, i[0], 3'h0});
         idle(2);
         `CHK("assign_map", map[i], ch_second_pair)
      end
      // Timer mode only: the special reset is not trusted with an unsynchronised count.
      wr(2'h1, 8'h77);
      wr(2'h3, 8'h02);
      cmp1_match <= 1'b1;
      idle(1);
      cmp1_match <= 1'b0;
      idle(1);
      `CHK("count_se", 16'h0000, count_value)
      rd(2'h3, 8'h02);
      wr(2'h0, 8'h08);
      cmp2_match <= 1'b1;
      wr(2'h1, 8'h55);
      cmp2_match <= 1'b0;
      idle(1);
      `CHK("adc_start", 1'b0, adc_start)
      `CHK("count_lo", 8'h55, count_value[7:0])
      cmp2_match <= 1'b1;
      idle(1);
      cmp2_match <= 1'b0;
      idle(1);
      `CHK("adc_start", 1'b1, adc_start)
      `CHK("count_se", 16'h0000, count_value)
      for (int s = 0; s < 2; s++) begin
         wr(2'h0, 8'h00);
         wr(2'h1, 8'h00);
         wr(2'h0, 8'h03 | 8'(s << 2));
         go <= 1'b1;
         idle(1);
         go <= 1'b0;
         n = 0;
         while (busy === 1'b1 && n < 100) begin
            idle(1);
            n++;
         end
         if (n == 100) begin
            n_fail++;
            wrap_up();
         end
         idle(8);
         `CHK("ext_count", 16'h0002, count_value)
      end
      wr(2'h0, 8'h80);
      wr(2'h2, 8'h12);
      idle(1);
      `CHK("count_buf", 16'h0002, count_value)
      wr(2'h1, 8'h34);
      idle(1);
      `CHK("count_wide", 16'h1234, count_value)
      rd(2'h1, 8'h34);
      rd(2'h2, 8'h12);
      port_out <= 2'h2;
      port_dir_out <= 2'h3;
      wr(2'h3, 8'h04);
      idle(3);
      `CHK("pin_out", 2'h2, pin_out)
      `CHK("pin_oe", 2'h0, pin_oe)
      `CHK("port_read", 2'h0, port_read)
      wr(2'h3, 8'h00);
      idle(3);
      `CHK("pin_oe", 2'h3, pin_oe)
      `CHK("port_read", 2'h2, port_read)
      wrap_up();
   end
endmodule
